/* include/roi_csr_cfg.svh */
// Offsets, fields, reset values and fixed answers of the region mode CSR block
`ifndef ROI_CSR_CFG_SVH
`define ROI_CSR_CFG_SVH
// Byte addresses relative to the camera register base
`define PTR_MODE0_ADDR 16'h02E0
`define PTR_MODE1_ADDR 16'h02E4
`define PTR_MODE0_VAL 32'h003C_2000
`define PTR_MODE1_VAL 32'h003C_2400
`define FERR_HI_ADDR 16'h0640
`define FERR_LO_ADDR 16'h0644
`define TEMP_ADDR 16'h082C
`define CTRL_ADDR 16'h0A00
`define ISTAT_ADDR 16'h0A04
`define IMASK_ADDR 16'h0A08
// Offsets inside one mode register set
`define OFS_MAX_EXT 12'h000
`define OFS_UNIT 12'h004
`define OFS_ORIGIN 12'h008
`define OFS_EXTENT 12'h00C
`define OFS_ENC_SEL 12'h010
`define OFS_ENC_CAP 12'h014
`define OFS_VENC_CAP 12'h024
`define OFS_PIX_CNT 12'h034
`define OFS_BYTES_HI 12'h038
`define OFS_BYTES_LO 12'h03C
`define OFS_PKT_INQ 12'h040
`define OFS_PKT_SET 12'h044
`define OFS_VSET 12'h07C
// Field positions
`define VSET_SETTING 30
`define VSET_FAULT_A 23
`define VSET_FAULT_B 22
`define TEMP_PRESENT 31
`define TEMP_ABS 30
`define TEMP_ON 25
`define CTRL_MODE 0
`define CTRL_EN 1
`define CTRL_INIT 31
`define IRQ_BLOCKED 0
`define IRQ_FAULT 1
// Fixed answers and reset values
`define MAX_W 16'h0800
`define MAX_H 16'h0600
`define UNIT_W 16'h0002
`define UNIT_H 16'h0002
`define ENC_CAP 32'h8000_0000
`define VENC_CAP 32'h0880_0000
`define ENC_DEFAULT 8'h00
`define ENC_VENDOR_MIN 8'h80
`define ENC_MONO12 8'h84
`define ENC_RAW12 8'h88
`define ENC_RSV_LO 8'h85
`define ENC_RSV_HI 8'h87
`define PKT_UNIT 16'h0004
`define PKT_MAX 16'h1000
// Temperature input in quarter degrees, output in tenths
`define TEMP_MIN_Q 11'sh724
`define TEMP_MAX_Q 11'sh258
`endif

/* include/roi_csr_pkg.sv */
// Types shared by the region mode CSR block
package roi_csr_pkg;
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} bus_st_t;
    typedef logic [15:0] addr_t;
endpackage : roi_csr_pkg

/* design/roi_mode_and_temp_csr.sv */
// Region mode CSR bank with temperature readout on an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
`include "roi_csr_cfg.svh"

// Overview of operation
// - Feature error words always read zero
// - Pointer gives mode 0 quadlet offset
// - Next pointer gives mode 1 offset
// - Fault flags recomputed on every set access
// - Setting bit self-clears; registers refresh each access
// - No capture while a fault flag of the active mode is set
// - Init or reset restores encoding selector
// - Packet unit size field fixed, pre-filled
// - Ids 128-255 vendor; 132/136 packed 12-bit
// - Temperature presence bit reads one
// - Temperature on bit always reads one
// - Temperature value in tenths of degrees
// - Displayed range -55 to 150, quarter steps
module roi_mode_and_temp_csr
    import roi_csr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic init_command_i,
    input wire logic capture_req_i,
    input wire logic signed [10:0] temp_quarter_i,
    output logic capture_start_o,
    output logic [0:0] active_mode_o,
    output logic irq_o
);

    // ****************************************
    // Storage
    // ****************************************
    bus_st_t bus_st_r;
    logic [31:0] readdata_r;
    logic [31:0] origin_r [2];
    logic [31:0] extent_r [2];
    logic [7:0] enc_sel_r [2];
    logic [15:0] pkt_bytes_r [2];
    logic [1:0] fault_a_r;
    logic [1:0] fault_b_r;
    logic [1:0] refresh_r;
    logic [31:0] ctrl_r;
    logic [1:0] istat_r;
    logic [1:0] imask_r;
    logic signed [11:0] temp_r;
    logic capture_r;
    logic [1:0] ev;
    logic [31:0] wmask;
    logic access;
    logic wr_ack;
    logic msel;
    logic mhit;
    logic [11:0] mofs;
    logic init_any;
    logic signed [10:0] tq_clamp;
    logic signed [13:0] t_tenths;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic in_mode(input addr_t a, input logic [31:0] p);
        in_mode = (a[15:12] == p[13:10]);
    endfunction : in_mode
    function automatic logic enc_packed(input logic [7:0] id);
        enc_packed = (id == `ENC_MONO12) || (id == `ENC_RAW12);
    endfunction : enc_packed
    function automatic logic enc_bad(input logic [7:0] id);
        enc_bad = (id >= `ENC_RSV_LO) && (id <= `ENC_RSV_HI);
    endfunction : enc_bad
    function automatic logic [31:0] pix_count(input logic [31:0] ext);
        pix_count = ext[31:16] * ext[15:0];
    endfunction : pix_count
    function automatic logic [31:0] frame_bytes(input logic [31:0] ext,
                                               input logic [7:0] id);
        logic [31:0] p;
        p = pix_count(ext);
        frame_bytes = enc_packed(id) ? p + (p >> 1) : p;
    endfunction : frame_bytes
    function automatic logic fault_geom(input logic [31:0] org,
                                        input logic [31:0] ext);
        logic [16:0] rx;
        logic [16:0] ry;
        rx = {1'b0, org[31:16]} + {1'b0, ext[31:16]};
        ry = {1'b0, org[15:0]} + {1'b0, ext[15:0]};
        fault_geom = (rx > {1'b0, `MAX_W}) || (ry > {1'b0, `MAX_H})
                     || (ext[31:16] == 16'h0000) || (ext[15:0] == 16'h0000);
    endfunction : fault_geom
    function automatic logic fault_pkt(input logic [15:0] b,
                                       input logic [7:0] id);
        fault_pkt = (b == 16'h0000) || (b > `PKT_MAX)
                    || ((b & (`PKT_UNIT - 16'h0001)) != 16'h0000)
                    || enc_bad(id);
    endfunction : fault_pkt

    // ****************************************
    // Bus decode
    // ****************************************
    assign access = (avs_read || avs_write) && (bus_st_r == BUS_ACK);
    assign wr_ack = avs_write && (bus_st_r == BUS_ACK);
    assign msel = avs_address[12];
    assign mhit = avs_address[15:13] == 3'b100
                  && (in_mode(avs_address, `PTR_MODE0_VAL)
                      || in_mode(avs_address, `PTR_MODE1_VAL));
    assign mofs = avs_address[11:0];
    assign init_any = init_command_i || (wr_ack
                      && avs_address == `CTRL_ADDR
                      && avs_writedata[`CTRL_INIT]);
    assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign avs_waitrequest = (avs_read || avs_write)
                             && (bus_st_r == BUS_IDLE);
    assign avs_readdata = readdata_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bus_st_r <= BUS_IDLE;
        end else begin
            case (bus_st_r)
                BUS_IDLE: bus_st_r <= (avs_read || avs_write) ? BUS_ACK
                                                               : BUS_IDLE;
                BUS_ACK: bus_st_r <= BUS_IDLE;
                default: bus_st_r <= BUS_IDLE;
            endcase
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            readdata_r <= 32'h0000_0000;
        end else if (avs_read && bus_st_r == BUS_IDLE) begin
            readdata_r <= 32'h0000_0000;
            if (mhit) begin
                case (mofs)
                    `OFS_MAX_EXT: readdata_r <= {`MAX_W, `MAX_H};
                    `OFS_UNIT: readdata_r <= {`UNIT_W, `UNIT_H};
                    `OFS_ORIGIN: readdata_r <= origin_r[msel];
                    `OFS_EXTENT: readdata_r <= extent_r[msel];
                    `OFS_ENC_SEL: readdata_r <= {enc_sel_r[msel], 24'h000000};
                    `OFS_ENC_CAP: readdata_r <= `ENC_CAP;
                    `OFS_VENC_CAP: readdata_r <= `VENC_CAP;
                    `OFS_PIX_CNT: readdata_r <= pix_count(extent_r[msel]);
                    `OFS_BYTES_HI: readdata_r <= 32'h0000_0000;
                    `OFS_BYTES_LO: begin
                        readdata_r <= frame_bytes(extent_r[msel],
                                                  enc_sel_r[msel]);
                    end
                    `OFS_PKT_INQ: readdata_r <= {`PKT_UNIT, `PKT_MAX};
                    `OFS_PKT_SET: readdata_r <= {pkt_bytes_r[msel], `PKT_MAX};
                    `OFS_VSET: begin
                        readdata_r[`VSET_FAULT_A] <= fault_a_r[msel];
                        readdata_r[`VSET_FAULT_B] <= fault_b_r[msel];
                    end
                    default: readdata_r <= 32'h0000_0000;
                endcase
            end else begin
                case (avs_address)
                    `PTR_MODE0_ADDR: readdata_r <= `PTR_MODE0_VAL;
                    `PTR_MODE1_ADDR: readdata_r <= `PTR_MODE1_VAL;
                    `FERR_HI_ADDR: readdata_r <= 32'h0000_0000;
                    `FERR_LO_ADDR: readdata_r <= 32'h0000_0000;
                    `TEMP_ADDR: begin
                        readdata_r[`TEMP_PRESENT] <= 1'b1;
                        readdata_r[`TEMP_ABS] <= 1'b0;
                        readdata_r[`TEMP_ON] <= 1'b1;
                        readdata_r[11:0] <= temp_r;
                    end
                    `CTRL_ADDR: readdata_r <= {1'b0, ctrl_r[30:0]};
                    `ISTAT_ADDR: readdata_r <= {30'h0000_0000, istat_r};
                    `IMASK_ADDR: readdata_r <= {30'h0000_0000, imask_r};
                    default: readdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************
    // Mode register sets
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int m = 0; m < 2; m++) begin
                origin_r[m] <= 32'h0000_0000;
                extent_r[m] <= {`MAX_W, `MAX_H};
                enc_sel_r[m] <= `ENC_DEFAULT;
                pkt_bytes_r[m] <= `PKT_MAX;
            end
        end else if (init_any) begin
            for (int m = 0; m < 2; m++) begin
                enc_sel_r[m] <= `ENC_DEFAULT;
            end
        end else if (wr_ack && mhit) begin
            case (mofs)
                `OFS_ORIGIN: begin
                    origin_r[msel] <= (origin_r[msel] & ~wmask)
                                      | (avs_writedata & wmask);
                end
                `OFS_EXTENT: begin
                    extent_r[msel] <= (extent_r[msel] & ~wmask)
                                      | (avs_writedata & wmask);
                end
                `OFS_ENC_SEL: begin
                    if (avs_byteenable[3]) begin
                        enc_sel_r[msel] <= avs_writedata[31:24];
                    end
                end
                `OFS_PKT_SET: begin
                    if (avs_byteenable[3] && avs_byteenable[2]) begin
                        pkt_bytes_r[msel] <= avs_writedata[31:16];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Fault flags follow two cycles after any access to a set
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            refresh_r <= 2'b00;
        end else begin
            refresh_r <= 2'b00;
            if (access && mhit) begin
                refresh_r[msel] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_a_r <= 2'b00;
            fault_b_r <= 2'b00;
        end else begin
            for (int m = 0; m < 2; m++) begin
                if (refresh_r[m]) begin
                    fault_a_r[m] <= fault_geom(origin_r[m], extent_r[m]);
                    fault_b_r[m] <= fault_pkt(pkt_bytes_r[m],
                                              enc_sel_r[m]);
                end
            end
        end
    end

    // ****************************************
    // Control and capture gating
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= 32'h0000_0000;
        end else if (wr_ack && avs_address == `CTRL_ADDR) begin
            ctrl_r <= {1'b0, 29'h0000_0000,
                       avs_writedata[`CTRL_EN], avs_writedata[`CTRL_MODE]};
        end
    end
    assign active_mode_o = ctrl_r[`CTRL_MODE];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            capture_r <= 1'b0;
        end else begin
            capture_r <= capture_req_i && ctrl_r[`CTRL_EN]
                         && !fault_a_r[ctrl_r[`CTRL_MODE]]
                         && !fault_b_r[ctrl_r[`CTRL_MODE]];
        end
    end
    assign capture_start_o = capture_r;

    // ****************************************
    // Interrupts
    // ****************************************
    assign ev[`IRQ_BLOCKED] = capture_req_i && ctrl_r[`CTRL_EN]
                              && (fault_a_r[ctrl_r[`CTRL_MODE]]
                                  || fault_b_r[ctrl_r[`CTRL_MODE]]);
    assign ev[`IRQ_FAULT] = |((refresh_r & fault_a_r)
                              | (refresh_r & fault_b_r));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            istat_r <= 2'b00;
        end else if (wr_ack && avs_address == `ISTAT_ADDR
                     && avs_byteenable[0]) begin
            istat_r <= (istat_r & ~avs_writedata[1:0]) | ev;
        end else begin
            istat_r <= istat_r | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            imask_r <= 2'b00;
        end else if (wr_ack && avs_address == `IMASK_ADDR
                     && avs_byteenable[0]) begin
            imask_r <= avs_writedata[1:0];
        end
    end

    assign irq_o = |(istat_r & imask_r);

    // ****************************************
    // Temperature
    // ****************************************
    always_comb begin
        tq_clamp = temp_quarter_i;
        if (temp_quarter_i < `TEMP_MIN_Q) begin
            tq_clamp = `TEMP_MIN_Q;
        end else if (temp_quarter_i > `TEMP_MAX_Q) begin
            tq_clamp = `TEMP_MAX_Q;
        end
        t_tenths = (14'(tq_clamp) * 14'sd5) >>> 1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            temp_r <= 12'sh000;
        end else begin
            temp_r <= t_tenths[11:0];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_ferr_zero;
        avs_read && !avs_waitrequest && !mhit
        && (avs_address == `FERR_HI_ADDR || avs_address == `FERR_LO_ADDR)
        |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_ferr_zero: assert property (p_ferr_zero)
        else $error("feature error word not zero");
    property p_ptr0;
        avs_read && !avs_waitrequest && avs_address == `PTR_MODE0_ADDR
        |-> avs_readdata == `PTR_MODE0_VAL;
    endproperty
    a_ptr0: assert property (p_ptr0)
        else $error("mode 0 pointer wrong");
    property p_ptr1;
        avs_read && !avs_waitrequest && avs_address == `PTR_MODE1_ADDR
        |-> avs_readdata == `PTR_MODE1_VAL;
    endproperty
    a_ptr1: assert property (p_ptr1)
        else $error("mode 1 pointer wrong");
    property p_refresh;
        access && mhit |=> refresh_r[$past(msel)];
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("fault flags not refreshed");
    property p_setting_clear;
        avs_read && !avs_waitrequest && mhit && mofs == `OFS_VSET
        |-> !avs_readdata[`VSET_SETTING];
    endproperty
    a_setting_clear: assert property (p_setting_clear)
        else $error("setting bit not cleared");
    property p_no_capture;
        (fault_a_r[ctrl_r[`CTRL_MODE]] || fault_b_r[ctrl_r[`CTRL_MODE]])
        && $stable(ctrl_r) |=> !capture_start_o;
    endproperty
    a_no_capture: assert property (p_no_capture)
        else $error("capture started with fault set");
    property p_init_enc;
        init_command_i |=> enc_sel_r[0] == `ENC_DEFAULT
                           && enc_sel_r[1] == `ENC_DEFAULT;
    endproperty
    a_init_enc: assert property (p_init_enc)
        else $error("encoding not restored");
    property p_temp_bits;
        avs_read && !avs_waitrequest && avs_address == `TEMP_ADDR
        |-> avs_readdata[`TEMP_PRESENT] && avs_readdata[`TEMP_ON]
            && avs_readdata[11:0] == $past(temp_r);
    endproperty
    a_temp_bits: assert property (p_temp_bits)
        else $error("temperature word wrong");
    property p_temp_range;
        temp_r >= -12'sd550 && temp_r <= 12'sd1500;
    endproperty
    a_temp_range: assert property (p_temp_range)
        else $error("temperature out of range");
endmodule : roi_mode_and_temp_csr
`default_nettype wire

/* dv/roi_host_model.sv */
// Host side model: Avalon-MM master and temperature decoding
`timescale 1ns/10ps
`default_nettype none
`include "roi_csr_cfg.svh"
module roi_host_model (
    input wire logic clk_i,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output var logic [15:0] avs_address,
    output var logic avs_read,
    output var logic avs_write,
    output var logic [31:0] avs_writedata,
    output var logic [3:0] avs_byteenable
);
    initial begin
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
    end
    // ************************************************
    // One bus cycle, held until waitrequest is low
    // ************************************************
    task automatic bus_xfer(input logic wr, input logic [15:0] a,
                            input logic [31:0] wd, output logic [31:0] rd,
                            output logic ok);
        int n;
        ok = 1'b0;
        rd = '0;
        @(posedge clk_i);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= 4'hF;
        avs_write <= wr;
        avs_read <= !wr;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_i);
            if (avs_waitrequest === 1'b0) begin
                ok = 1'b1;
                rd = avs_readdata;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_xfer
    // ************************************************
    // Value field is dropped when absolute control is set
    // ************************************************
    function automatic logic [11:0] temp_field(input logic [31:0] w);
        return w[`TEMP_ABS] ? 12'h000 : w[11:0];
    endfunction : temp_field
endmodule : roi_host_model
`default_nettype wire

/* dv/roi_mode_and_temp_csr_tb_top.sv */
// Self-checking bench of the region mode CSR bank
`timescale 1ns/10ps
`default_nettype none
`include "roi_csr_cfg.svh"
module roi_mode_and_temp_csr_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic init_command_i = 1'b0;
    logic capture_req_i = 1'b0;
    logic signed [10:0] temp_quarter_i = 11'sh000;
    logic capture_start_o;
    logic [0:0] active_mode_o;
    logic irq_o;
    int bad_count = 0;
    int checked = 0;
    localparam logic [15:0] M0 = 16'h8000;
    localparam logic [15:0] M1 = 16'h9000;
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    roi_mode_and_temp_csr i_roi_mode_and_temp_csr (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .init_command_i(init_command_i),
        .capture_req_i(capture_req_i), .temp_quarter_i(temp_quarter_i),
        .capture_start_o(capture_start_o), .active_mode_o(active_mode_o),
        .irq_o(irq_o));
    roi_host_model i_roi_host_model (.clk_i(clk_i),
        .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable));
    // ************************************************
    // Shared helpers
    // ************************************************
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic ok;
        i_roi_host_model.bus_xfer(1'b1, a, d, r, ok);
        if (!ok) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        logic ok;
        i_roi_host_model.bus_xfer(1'b0, a, 32'h0, d, ok);
        if (!ok) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : rd
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask : rdchk
    task automatic pulse_capture(input logic exp);
        @(posedge clk_i);
        capture_req_i <= 1'b1;
        @(posedge clk_i);
        capture_req_i <= 1'b0;
        @(posedge clk_i);
        check({31'h0, capture_start_o}, {31'h0, exp});
    endtask : pulse_capture
    // ************************************************
    // Scenarios
    // ************************************************
    task automatic s_fixed_words();
        logic [31:0] d;
        rdchk(`PTR_MODE0_ADDR, 32'h003C_2000);
        rd(`PTR_MODE0_ADDR, d);
        check(32'hF000_0000 + (d << 2), 32'hF0F0_0000 + M0);
        rd(`PTR_MODE1_ADDR, d);
        check(32'hF000_0000 + (d << 2), 32'hF0F0_0000 + M1);
        wr(`FERR_HI_ADDR, 32'hFFFF_FFFF);
        wr(`FERR_LO_ADDR, 32'hFFFF_FFFF);
        rdchk(`FERR_HI_ADDR, 32'h0);
        rdchk(`FERR_LO_ADDR, 32'h0);
        rdchk(M0 + `OFS_PKT_INQ, 32'h0004_1000);
        rdchk(M1 + `OFS_PKT_INQ, 32'h0004_1000);
        rdchk(M0 + `OFS_EXTENT, 32'h0800_0600);
        rdchk(M0 + `OFS_VENC_CAP, 32'h0880_0000);
        rdchk(M0 + `OFS_MAX_EXT, {`MAX_W, `MAX_H});
        rdchk(M1 + `OFS_UNIT, {`UNIT_W, `UNIT_H});
        rdchk(M1 + `OFS_ENC_CAP, `ENC_CAP);
        rdchk(M1 + `OFS_PKT_SET, {`PKT_MAX, `PKT_MAX});
        rdchk(M1 + `OFS_BYTES_HI, 32'h0);
        wr(M1 + `OFS_ORIGIN, 32'h0010_0020);
        rdchk(M1 + `OFS_ORIGIN, 32'h0010_0020);
        wr(16'h0100, 32'hFFFF_FFFF);
        rdchk(16'h0100, 32'h0);
    endtask : s_fixed_words
    task automatic s_temperature();
        int qs[6] = '{0, 100, -220, 600, 700, -300};
        int q;
        logic [31:0] d;
        wr(`TEMP_ADDR, 32'h0);
        foreach (qs[i]) begin
            @(posedge clk_i);
            temp_quarter_i <= 11'(qs[i]);
            q = qs[i] < -220 ? -220 : (qs[i] > 600 ? 600 : qs[i]);
            rd(`TEMP_ADDR, d);
            rd(`TEMP_ADDR, d);
            check(d & 32'hFFFF_F000, 32'h8200_0000);
            check({20'h0, i_roi_host_model.temp_field(d)},
                  {20'h0, 12'(q * 10 / 4)});
        end
    endtask : s_temperature
    task automatic s_fault_and_capture();
        wr(`CTRL_ADDR, 32'h0000_0002);
        wr(`IMASK_ADDR, 32'h0);
        pulse_capture(1'b1);
        wr(M0 + `OFS_EXTENT, 32'h0801_0600);
        rdchk(M0 + `OFS_VSET, 32'h0080_0000);
        rdchk(M0 + `OFS_VSET, 32'h0080_0000);
        wr(M0 + `OFS_VSET, 32'h4000_0000);
        rdchk(M0 + `OFS_VSET, 32'h0080_0000);
        pulse_capture(1'b0);
        wr(`IMASK_ADDR, 32'h1);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h1);
        wr(`IMASK_ADDR, 32'h0);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        wr(M0 + `OFS_EXTENT, 32'h0800_0600);
        rdchk(M0 + `OFS_VSET, 32'h0);
        rdchk(M0 + `OFS_VSET, 32'h0);
        wr(`ISTAT_ADDR, 32'h3);
        rdchk(`ISTAT_ADDR, 32'h0);
        wr(`IMASK_ADDR, 32'h3);
        @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        pulse_capture(1'b1);
    endtask : s_fault_and_capture
    task automatic s_encodings();
        logic [31:0] e;
        for (int id = 132; id <= 136; id++) begin
            e = (id >= 133 && id <= 135) ? 32'h0040_0000 : 32'h0;
            wr(M0 + `OFS_ENC_SEL, {8'(id), 24'h0});
            rdchk(M0 + `OFS_ENC_SEL, {8'(id), 24'h0});
            rdchk(M0 + `OFS_VSET, e);
            rdchk(M0 + `OFS_VSET, e);
        end
        rdchk(M0 + `OFS_PIX_CNT, 32'h0030_0000);
        rdchk(M0 + `OFS_BYTES_LO, 32'h0048_0000);
        pulse_capture(1'b1);
    endtask : s_encodings
    task automatic s_init_and_reset();
        wr(`CTRL_ADDR, 32'h0000_0003);
        @(posedge clk_i);
        check({31'h0, active_mode_o}, 32'h1);
        wr(M1 + `OFS_ENC_SEL, 32'h8400_0000);
        rdchk(M1 + `OFS_ENC_SEL, 32'h8400_0000);
        @(posedge clk_i);
        init_command_i <= 1'b1;
        @(posedge clk_i);
        init_command_i <= 1'b0;
        rdchk(M1 + `OFS_ENC_SEL, 32'h0);
        rdchk(M0 + `OFS_ENC_SEL, 32'h0);
        wr(M0 + `OFS_ENC_SEL, 32'h8800_0000);
        wr(`CTRL_ADDR, 32'h8000_0003);
        check({31'h0, active_mode_o}, 32'h1);
        rdchk(M0 + `OFS_ENC_SEL, 32'h0);
        wr(M1 + `OFS_ENC_SEL, 32'h8800_0000);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        check({31'h0, active_mode_o}, 32'h0);
        rdchk(M1 + `OFS_ENC_SEL, 32'h0);
    endtask : s_init_and_reset
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        s_fixed_words();
        s_temperature();
        s_fault_and_capture();
        s_encodings();
        s_init_and_reset();
        tally_and_finish();
    end
endmodule : roi_mode_and_temp_csr_tb_top
`default_nettype wire
